// [shared/mua_pkg.sv]
// Contract
// - Multiply-and-add sets null flag if sum is zero, msb flag from sum bit 31.
// - Multiply-and-add sets carry when the addition carries out, else clears it.
// - Add and subtract forms set range flag on signed overflow, else leave it.
// - Without saturation, positive overflow increments tally, negative overflow decrements it.
// - With saturation enabled, overflow clamps sum to 0x7FFFFFFF or 0x80000000.
// - Previous product shifts first: positive left with zero fill, negative arithmetic right.
// - Add form adds shifted product to sum and loads product with new upper half.
// - Plain form stores upper 32 bits of signed 32x32 product in product register.
// - Plain form decoded from two words, locator in low byte; one cycle; object mode 1.
// - Sum-destination form writes upper product half straight into the sum register.
// - Sum-destination form sets null flag if sum zero, msb flag from bit 31.
// - Sum-destination form has its own first word plus locator word; takes two cycles.
// - Subtract form subtracts shifted product from sum and loads product with new half.
// - Subtract form sets null flag if sum zero, msb flag from sum bit 31.
// - Subtract form clears carry on borrow and sets it when no borrow.
// - Subtract form has its own first word plus locator word; one cycle; object mode 1.
// - These multiplies never repeat: they clear the repeat countdown and run once.
package mua_pkg;

  localparam int DATA_W = 32;
  localparam int OVC_W = 6;
  localparam int PM_W = 5;
  localparam int RPT_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SUM = 8'h08;
  localparam logic [7:0] OFF_PROD = 8'h0C;
  localparam logic [7:0] OFF_MULT = 8'h10;
  localparam logic [7:0] OFF_TALLY = 8'h14;
  localparam logic [7:0] OFF_RPT = 8'h18;

  // Control fields
  localparam int CTRL_SAT_BIT = 0;
  localparam int CTRL_OBJ_BIT = 1;
  localparam int CTRL_PM_LSB = 4;

  // Status fields
  localparam int ST_NULL_BIT = 0;
  localparam int ST_MSB_BIT = 1;
  localparam int ST_CARRY_BIT = 2;
  localparam int ST_RANGE_BIT = 3;
  localparam int ST_ILL_BIT = 4;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [PM_W-1:0] RST_PM = 5'h00;

  // Instruction words
  localparam logic [15:0] OPC_PLAIN = 16'h5667;
  localparam logic [15:0] OPC_SUMDEST = 16'h5663;
  localparam logic [15:0] OPC_ADD = 16'h5646;
  localparam logic [15:0] OPC_SUB = 16'h5645;
  localparam logic [7:0] OPC_W1_HIGH = 8'h00;

  localparam logic [31:0] SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG = 32'h8000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_PLAIN,
    OP_SUMDEST,
    OP_ADD,
    OP_SUB
  } mua_op_t;

  typedef struct packed {
    logic [15:0] word0;
    logic [15:0] word1;
    logic [31:0] operand;
  } mua_issue_t;

  typedef struct packed {
    logic null_f;
    logic msb_f;
    logic carry_f;
    logic range_f;
  } mua_flags_t;

endpackage

// [rtl/mua_mul_high.sv]
`timescale 1ns/10ps
module mua_mul_high #(
  parameter int W = 32
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [W-1:0] high
);
  logic signed [2*W-1:0] prod;

  always_comb begin
    prod = $signed(a) * $signed(b);
    high = prod[2*W-1:W];
  end
endmodule // mua_mul_high

// [rtl/mua_prod_shift.sv]
`timescale 1ns/10ps
module mua_prod_shift #(
  parameter int W = 32,
  parameter int SW = 5
) (
  input wire logic [W-1:0] din,
  input wire logic [SW-1:0] sel,
  output logic [W-1:0] dout
);
  logic [SW-1:0] amt;

  // Selection is two's complement: positive shifts left, negative shifts right
  always_comb begin
    amt = SW'(-sel);
    if (sel[SW-1]) begin
      dout = W'($signed(din) >>> amt);
    end else begin
      dout = din << sel;
    end
  end
endmodule // mua_prod_shift

// [rtl/mua_top.sv]
`timescale 1ns/10ps
module mua_top (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoder issue port
  input wire mua_pkg::mua_issue_t issue,
  input wire logic issue_valid,
  output logic issue_ready,
  output logic done_q,
  output logic reject_q,
  output logic [7:0] operand_locator_q
);

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SUMDEST
  } mua_state_t;

  mua_state_t state_q;
  logic saturate_enable_q;
  logic object_mode_bit_q;
  logic [mua_pkg::PM_W-1:0] product_shift_sel_q;
  logic [31:0] sum_register_q;
  logic [31:0] product_q;
  logic [31:0] multiplicand_reg_q;
  logic [mua_pkg::OVC_W-1:0] overflow_tally_q;
  logic [mua_pkg::RPT_W-1:0] repeat_countdown_q;
  mua_pkg::mua_flags_t flags_q;
  logic illegal_q;
  logic [31:0] pending_q;

  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  function automatic mua_pkg::mua_op_t decode_op(input logic [15:0] w0, input logic [15:0] w1);
    mua_pkg::mua_op_t op;
    op = mua_pkg::OP_NONE;
    if (w1[15:8] == mua_pkg::OPC_W1_HIGH) begin
      unique case (w0)
        mua_pkg::OPC_PLAIN: op = mua_pkg::OP_PLAIN;
        mua_pkg::OPC_SUMDEST: op = mua_pkg::OP_SUMDEST;
        mua_pkg::OPC_ADD: op = mua_pkg::OP_ADD;
        mua_pkg::OPC_SUB: op = mua_pkg::OP_SUB;
        default: op = mua_pkg::OP_NONE;
      endcase
    end
    return op;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Datapath
  mua_pkg::mua_op_t op;
  logic take;
  logic exec_ok;
  logic [31:0] mul_hi;
  logic [31:0] shifted;
  logic [32:0] add_full;
  logic [31:0] diff;
  logic [31:0] raw;
  logic carry_n;
  logic ovf;
  logic ovf_pos;
  logic [31:0] acc_result;

  mua_mul_high #(
    .W(32)
  ) u_mul (
    .a(multiplicand_reg_q),
    .b(issue.operand),
    .high(mul_hi)
  );

  mua_prod_shift #(
    .W(32),
    .SW(mua_pkg::PM_W)
  ) u_shift (
    .din(product_q),
    .sel(product_shift_sel_q),
    .dout(shifted)
  );

  always_comb begin
    op = decode_op(issue.word0, issue.word1);
    take = issue_valid && issue_ready;
    exec_ok = take && (op != mua_pkg::OP_NONE) && object_mode_bit_q;
    add_full = {1'b0, sum_register_q} + {1'b0, shifted};
    diff = sum_register_q - shifted;
    if (op == mua_pkg::OP_SUB) begin
      raw = diff;
      carry_n = (sum_register_q >= shifted);
      ovf = (sum_register_q[31] != shifted[31]) && (diff[31] != sum_register_q[31]);
    end else begin
      raw = add_full[31:0];
      carry_n = add_full[32];
      ovf = (sum_register_q[31] == shifted[31]) && (add_full[31] != sum_register_q[31]);
    end
    // Overflow sign follows the original sum: a positive sum can only overflow upward
    ovf_pos = ovf && !sum_register_q[31];
    if (ovf && saturate_enable_q) begin
      acc_result = ovf_pos ? mua_pkg::SAT_POS : mua_pkg::SAT_NEG;
    end else begin
      acc_result = raw;
    end
  end

  logic accum_exec;
  assign accum_exec = exec_ok && (op == mua_pkg::OP_ADD || op == mua_pkg::OP_SUB);

  // Decoder handshake: the two-cycle form stalls the next issue
  assign issue_ready = (state_q == ST_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      pending_q <= mua_pkg::RST_WORD;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (exec_ok && op == mua_pkg::OP_SUMDEST) begin
            state_q <= ST_SUMDEST;
            pending_q <= mul_hi;
          end
        end
        ST_SUMDEST: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      reject_q <= 1'b0;
      operand_locator_q <= 8'h00;
    end else begin
      done_q <= (exec_ok && op != mua_pkg::OP_SUMDEST) || (state_q == ST_SUMDEST);
      reject_q <= take && !exec_ok;
      if (take) begin
        operand_locator_q <= issue.word1[7:0];
      end
    end
  end

  // AXI write channel capture
  logic wr_fire;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= mua_pkg::RST_WORD;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mua_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_q)
          mua_pkg::OFF_CTRL, mua_pkg::OFF_STATUS, mua_pkg::OFF_SUM, mua_pkg::OFF_PROD,
          mua_pkg::OFF_MULT, mua_pkg::OFF_TALLY, mua_pkg::OFF_RPT:
            s_axi_bresp <= mua_pkg::RESP_OKAY;
          default: s_axi_bresp <= mua_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_hit(input logic fire, input logic [7:0] a, input logic [7:0] off);
    return fire && (a == off);
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  always_comb begin
    ctrl_word = '0;
    ctrl_word[mua_pkg::CTRL_SAT_BIT] = saturate_enable_q;
    ctrl_word[mua_pkg::CTRL_OBJ_BIT] = object_mode_bit_q;
    ctrl_word[mua_pkg::CTRL_PM_LSB +: mua_pkg::PM_W] = product_shift_sel_q;
    status_word = '0;
    status_word[mua_pkg::ST_NULL_BIT] = flags_q.null_f;
    status_word[mua_pkg::ST_MSB_BIT] = flags_q.msb_f;
    status_word[mua_pkg::ST_CARRY_BIT] = flags_q.carry_f;
    status_word[mua_pkg::ST_RANGE_BIT] = flags_q.range_f;
    status_word[mua_pkg::ST_ILL_BIT] = illegal_q;
  end

  logic [31:0] ctrl_new;
  logic [31:0] status_new;
  assign ctrl_new = merge_strb(ctrl_word, w_data_q, w_strb_q);
  assign status_new = merge_strb(status_word, w_data_q, w_strb_q);

  // Control register: only software writes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saturate_enable_q <= 1'b0;
      object_mode_bit_q <= 1'b0;
      product_shift_sel_q <= mua_pkg::RST_PM;
    end else if (wr_hit(wr_fire, aw_addr_q, mua_pkg::OFF_CTRL)) begin
      saturate_enable_q <= ctrl_new[mua_pkg::CTRL_SAT_BIT];
      object_mode_bit_q <= ctrl_new[mua_pkg::CTRL_OBJ_BIT];
      product_shift_sel_q <= ctrl_new[mua_pkg::CTRL_PM_LSB +: mua_pkg::PM_W];
    end
  end

  // Sum register: an executing instruction wins over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_register_q <= mua_pkg::RST_WORD;
    end else if (state_q == ST_SUMDEST) begin
      sum_register_q <= pending_q;
    end else if (accum_exec) begin
      sum_register_q <= acc_result;
    end else if (wr_hit(wr_fire, aw_addr_q, mua_pkg::OFF_SUM)) begin
      sum_register_q <= merge_strb(sum_register_q, w_data_q, w_strb_q);
    end
  end

  // Product register: loaded by the plain, add and subtract forms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      product_q <= mua_pkg::RST_WORD;
    end else if (exec_ok && op != mua_pkg::OP_SUMDEST) begin
      product_q <= mul_hi;
    end else if (wr_hit(wr_fire, aw_addr_q, mua_pkg::OFF_PROD)) begin
      product_q <= merge_strb(product_q, w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      multiplicand_reg_q <= mua_pkg::RST_WORD;
    end else if (wr_hit(wr_fire, aw_addr_q, mua_pkg::OFF_MULT)) begin
      multiplicand_reg_q <= merge_strb(multiplicand_reg_q, w_data_q, w_strb_q);
    end
  end

  // Flags: plain form touches none of them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
      illegal_q <= 1'b0;
    end else begin
      if (wr_hit(wr_fire, aw_addr_q, mua_pkg::OFF_STATUS)) begin
        flags_q.null_f <= status_new[mua_pkg::ST_NULL_BIT];
        flags_q.msb_f <= status_new[mua_pkg::ST_MSB_BIT];
        flags_q.carry_f <= status_new[mua_pkg::ST_CARRY_BIT];
        flags_q.range_f <= status_new[mua_pkg::ST_RANGE_BIT];
        illegal_q <= status_new[mua_pkg::ST_ILL_BIT];
      end
      if (state_q == ST_SUMDEST) begin
        flags_q.null_f <= (pending_q == 32'h0000_0000);
        flags_q.msb_f <= pending_q[31];
      end else if (accum_exec) begin
        flags_q.null_f <= (acc_result == 32'h0000_0000);
        flags_q.msb_f <= acc_result[31];
        flags_q.carry_f <= carry_n;
        if (ovf) begin
          flags_q.range_f <= 1'b1;
        end
      end
      if (take && !exec_ok) begin
        illegal_q <= 1'b1;
      end
    end
  end

  // Overflow tally wraps at its width, like any small counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_tally_q <= '0;
    end else if (accum_exec && ovf && !saturate_enable_q) begin
      if (ovf_pos) begin
        overflow_tally_q <= overflow_tally_q + 1'b1;
      end else begin
        overflow_tally_q <= overflow_tally_q - 1'b1;
      end
    end else if (wr_hit(wr_fire, aw_addr_q, mua_pkg::OFF_TALLY)) begin
      overflow_tally_q <= w_data_q[mua_pkg::OVC_W-1:0];
    end
  end

  // Countdown is loaded by the repeat instruction elsewhere; software stands in here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      repeat_countdown_q <= '0;
    end else if (exec_ok) begin
      repeat_countdown_q <= '0;
    end else if (wr_hit(wr_fire, aw_addr_q, mua_pkg::OFF_RPT)) begin
      repeat_countdown_q <= w_data_q[mua_pkg::RPT_W-1:0];
    end
  end

  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= mua_pkg::RST_WORD;
      s_axi_rresp <= mua_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mua_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        mua_pkg::OFF_CTRL: s_axi_rdata <= ctrl_word;
        mua_pkg::OFF_STATUS: s_axi_rdata <= status_word;
        mua_pkg::OFF_SUM: s_axi_rdata <= sum_register_q;
        mua_pkg::OFF_PROD: s_axi_rdata <= product_q;
        mua_pkg::OFF_MULT: s_axi_rdata <= multiplicand_reg_q;
        mua_pkg::OFF_TALLY: s_axi_rdata <= 32'(overflow_tally_q);
        mua_pkg::OFF_RPT: s_axi_rdata <= 32'(repeat_countdown_q);
        default: begin
          s_axi_rdata <= mua_pkg::RST_WORD;
          s_axi_rresp <= mua_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // mua_top

// [testbench/mua_top_sva.sv]
`timescale 1ns/10ps
module mua_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire mua_pkg::mua_issue_t issue,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire logic done_q,
  input wire logic reject_q,
  input wire logic [7:0] operand_locator_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire take = issue_valid && issue_ready;
  wire stall = !issue_ready;
  wire [15:0] w0 = issue.word0;
  wire w1_ok = issue.word1[15:8] == mua_pkg::OPC_W1_HIGH;
  wire one_cyc = w0 == mua_pkg::OPC_PLAIN || w0 == mua_pkg::OPC_ADD || w0 == mua_pkg::OPC_SUB;
  wire sum_dst = w0 == mua_pkg::OPC_SUMDEST;
  // Second cycle of the sum-destination form blocks the port, then completes
  sequence s_sd_run;
    (stall && !done_q) ##1 (done_q && issue_ready);
  endsequence
  AST_ONE_CYC: assert property (take && one_cyc |=> done_q != reject_q)
    else $error("single cycle form gave no single outcome");
  AST_SD_TWO: assert property (take && sum_dst && w1_ok |=> reject_q or s_sd_run)
    else $error("sum destination form not two cycles");
  AST_BAD_W1: assert property (take && !w1_ok |=> reject_q && !done_q)
    else $error("bad second word not refused");
  AST_BAD_OP: assert property (take && !one_cyc && !sum_dst |=> reject_q && !done_q)
    else $error("unknown first word not refused");
  AST_LOC: assert property (take |=> operand_locator_q == $past(issue.word1[7:0]))
    else $error("operand locator not captured");
  AST_REJ_CAUSE: assert property (reject_q |-> $past(take))
    else $error("refusal without an issue");
  AST_DONE_CAUSE: assert property (done_q |-> $past(take) || $past(stall))
    else $error("completion without an issue");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // mua_top_sva

bind mua_top mua_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .issue(issue), .issue_valid(issue_valid),
  .issue_ready(issue_ready), .done_q(done_q), .reject_q(reject_q),
  .operand_locator_q(operand_locator_q));

// [testbench/mua_top_bench.sv]
`timescale 1ns/10ps
module mua_top_bench;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awa = 0, ara = 0, loc;
  logic awv = 0, wv = 0, arv = 0, iv = 0, brdy = 1, rrdy = 1;
  logic awr, wrdy, bv, arr, rv, ir, dn, rj;
  logic [31:0] wd = 0, rdat;
  logic [1:0] bresp, rresp;
  mua_pkg::mua_issue_t iss_s = '0;
  int miscompares = 0, n_compared = 0, cyc = 0, seed = 31623;
  logic [33:0] rq[$];
  logic [9:0] dq[$];
  logic [31:0] m_sum = 0, m_prod = 0, m_mult = 0;
  logic [31:0] sv[4] = '{32'h7FFF_FFF0, 32'h8000_0010, 32'h0000_0000, 32'h1234_5678};
  logic [15:0] ops[5] = '{16'h5667, 16'h5663, 16'h5646, 16'h5645, 16'h5647};
  logic [7:0] m_rpt = 0;
  logic [5:0] m_tal = 0;
  logic [4:0] m_st = 0, m_pm = 0;
  logic m_sat = 0, m_obj = 0;

  mua_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .issue(iss_s),
    .issue_valid(iv), .issue_ready(ir), .done_q(dn), .reject_q(rj), .operand_locator_q(loc));

  initial forever #4 aclk = ~aclk;

  task check(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rv && rrdy) begin
      check("rdata", rq[0], {rresp, rdat});
      rq.pop_front();
    end
    if (dn || rj) begin
      check("outcome", dq[0], {dn, rj, loc});
      dq.pop_front();
    end
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wdn, an, wn;
    ad = 0;
    wdn = 0;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    brdy <= 1'($random(seed));
    while (!(ad && wdn)) begin
      @(negedge aclk);
      an = awr && awv;
      wn = wrdy && wv;
      @(posedge aclk);
      if (an) begin
        awv <= 0;
        ad = 1;
      end
      if (wn) begin
        wv <= 0;
        wdn = 1;
      end
    end
    do @(negedge aclk); while (!bv);
    check("bresp", er, bresp);
    // A late bready makes the slave hold its response for a cycle
    if (!brdy) begin
      @(posedge aclk);
      brdy <= 1;
    end
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    ara <= a;
    arv <= 1;
    rrdy <= 1'($random(seed));
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 0;
    if (!rrdy) begin
      @(posedge aclk);
      rrdy <= 1;
    end
    do @(negedge aclk); while (!rv);
    @(posedge aclk);
  endtask

  task setreg(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, mua_pkg::RESP_OKAY);
    case (a)
      8'h00: {m_pm, m_obj, m_sat} = {d[8:4], d[1], d[0]};
      8'h04: m_st = d[4:0];
      8'h08: m_sum = d;
      8'h0C: m_prod = d;
      8'h10: m_mult = d;
      8'h14: m_tal = d[5:0];
      default: m_rpt = d[7:0];
    endcase
  endtask

  // Reference accumulate: shift, add or subtract, overflow handling
  task acc(input bit add);
    logic [31:0] sh, r;
    logic [32:0] t;
    logic [4:0] n;
    logic ov;
    n = -m_pm;
    // Kept apart: a mixed-sign conditional would turn the right shift logical
    if (m_pm[4]) sh = $signed(m_prod) >>> n;
    else sh = m_prod << m_pm;
    t = add ? {1'b0, m_sum} + {1'b0, sh} : {1'b0, m_sum} - {1'b0, sh};
    r = t[31:0];
    ov = (add ? m_sum[31] == sh[31] : m_sum[31] != sh[31]) && r[31] != m_sum[31];
    m_st[2] = add ? t[32] : !t[32];
    if (ov) begin
      m_st[3] = 1;
      if (m_sat) r = m_sum[31] ? 32'h8000_0000 : 32'h7FFF_FFFF;
      else m_tal = m_sum[31] ? m_tal - 6'h01 : m_tal + 6'h01;
    end
    m_sum = r;
    m_st[1:0] = {r[31], r == 32'h0000_0000};
  endtask

  task iss(input logic [15:0] w0, input logic [15:0] w1, input logic [31:0] op, input bit keep);
    logic signed [63:0] p;
    logic ok;
    iss_s <= '{w0, w1, op};
    iv <= 1;
    do @(negedge aclk); while (!ir);
    ok = m_obj && w1[15:8] == 8'h00 && w0 inside {16'h5667, 16'h5663, 16'h5646, 16'h5645};
    p = $signed(m_mult) * $signed(op);
    if (!ok) m_st[4] = 1;
    else begin
      if (w0 == 16'h5663) begin
        m_sum = p[63:32];
        m_st[1:0] = {p[63], p[63:32] == 32'h0000_0000};
      end
      else if (w0 != 16'h5667) acc(w0 == 16'h5646);
      if (w0 != 16'h5663) m_prod = p[63:32];
      m_rpt = 0;
    end
    dq.push_back({ok ? 2'b10 : 2'b01, w1[7:0]});
    @(posedge aclk);
    // A dropped request idles a cycle, so the next call never re-raises it at once
    if (!keep) begin
      iv <= 0;
      @(posedge aclk);
    end
  endtask

  task chk();
    rd(8'h08, {2'b00, m_sum});
    rd(8'h0C, {2'b00, m_prod});
    rd(8'h04, {29'h0, m_st});
    rd(8'h14, {28'h0, m_tal});
    rd(8'h18, {26'h0, m_rpt});
  endtask

  initial begin
    logic [31:0] r;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk();
    rd(8'h00, 34'h0);
    rd(8'h10, 34'h0);
    $display("reset values done");
    iss(16'h5667, 16'h0011, 32'h0000_0005, 0);
    chk();
    setreg(8'h04, 32'h0);
    setreg(8'h00, 32'h2);
    setreg(8'h18, 32'h5);
    setreg(8'h10, 32'h4000_0000);
    iss(16'h5667, 16'h00A5, 32'h8000_0000, 0);
    chk();
    wr(8'h1C, 32'h1, mua_pkg::RESP_SLVERR);
    rd(8'h1C, {mua_pkg::RESP_SLVERR, 32'h0});
    setreg(8'h08, 32'h1234_0000);
    setreg(8'h0C, 32'h1234_0000);
    iss(16'h5645, 16'h0000, 32'h0, 0);
    chk();
    $display("directed forms done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      setreg(8'h00, (r & 32'h0000_01F1) | 32'h2);
      setreg(8'h10, $random(seed));
      setreg(8'h08, sv[r[13:12]]);
      for (int j = 0; j < 3; j++) begin
        r = $random(seed);
        iss(ops[r[2:0] % 5], {(r[6:4] == 0) ? 8'h01 : 8'h00, r[15:8]}, $random(seed),
          j < 2 && r[16]);
      end
      chk();
    end
    $display("random sequences done");
    repeat (4) @(posedge aclk);
    check("pending", 34'h0, rq.size() + dq.size());
    finish_test();
  end
endmodule // mua_top_bench
